// file: rtl/rse_exec.sv
// Return / return-subvert execution unit with return stack and subvert handling.
// Assumes decode presents one instruction per instr_valid_i cycle with operands already read.
// Summary of operation
// - Opcode 62 return, 63 return-subvert
// - Only register-register and long-immediate formats accepted
// - Result tag from source1 or immediate
// - Trap when operand tag matches a non-zero type field
// - Program counter loaded from return stack top
// - Window pointer decremented by one
// - Underflow trap when pointer equals limit
// - Argument count loaded when field top set
// - Destination gets tag merge or immediate
// - Immediate operand never tag checked
// - Return-subvert sets the subvert flag
// - Subvert flag alters the next instruction
// - Copy classes write trap result, no checks
// - Copy classes inhibit register side effects
// - Subverted call/return write trap result
// - Subverted call checks trap result tag
// - Subverted return skips all tag checks
// - Subverted conditional branches on bit mismatch
// - Subverted store does nothing at all
// - Other subverted classes left undefined
// - Call pushes return address, increments pointer
//
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module rse_exec
	import rse_pkg::*;
#(
	parameter int WBP_W = 4
) (
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// Wishbone slave
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	// Instruction from decode
	input  wire logic                instr_valid_i,
	input  wire logic [INSTR_W-1:0]  instr_i,
	input  wire logic [WORD_W-1:0]   imm_i,
	input  wire logic [3:0]          class_i,
	input  wire logic [DATA_W-1:0]   pc_i,
	input  wire logic [WORD_W-1:0]   src1_i,
	input  wire logic [WORD_W-1:0]   src2_i,
	// Results
	output logic                     pc_load_o,
	output logic      [DATA_W-1:0]   pc_o,
	output logic                     rf_we_o,
	output logic      [5:0]          rf_waddr_o,
	output logic      [WORD_W-1:0]   rf_wdata_o,
	output logic      [4:0]          nargs_o,
	output logic                     branch_take_o,
	output logic                     side_fx_inhibit_o,
	output logic                     trap_o,
	output logic      [1:0]          trap_code_o,
	output logic                     subvert_o
);

	////////////////////////////////////////////////////////////////////////////////
	// State
	localparam int DEPTH = 1 << WBP_W;

	logic [DATA_W-1:0] ret_stack [DEPTH];
	logic [WBP_W-1:0]  wbp_r,  wbp_nxt;
	logic [WBP_W-1:0]  ufl_r,  ufl_nxt;
	logic [WORD_W-1:0] trap_res_r, trap_res_nxt;
	logic              subvert_r, subvert_nxt;
	logic [4:0]        nargs_r, nargs_nxt;
	logic              ack_r, ack_nxt;
	logic [31:0]       rdat_r, rdat_nxt;
	logic              pc_load_r, pc_load_nxt;
	logic [DATA_W-1:0] pc_r, pc_nxt;
	logic              rf_we_r, rf_we_nxt;
	logic [5:0]        rf_waddr_r, rf_waddr_nxt;
	logic [WORD_W-1:0] rf_wdata_r, rf_wdata_nxt;
	logic              br_r, br_nxt;
	logic              inhibit_r, inhibit_nxt;
	logic              trap_r, trap_nxt;
	logic [1:0]        trap_code_r, trap_code_nxt;
	logic              push_en;
	logic [WBP_W-1:0]  push_idx;
	logic [DATA_W-1:0] push_val;

	////////////////////////////////////////////////////////////////////////////////
	// Decode
	logic [2:0]        fmt;
	logic [5:0]        opc;
	logic [TYPE_W-1:0] type_f;
	logic              is_rr, is_ril, fmt_ok;
	logic              is_ret, is_rsv, is_call;
	logic              ufl_hit, tag_trap, exec_ret_ok, exec_call_ok, cls_copy;
	logic [DATA_W-1:0] stack_top;
	logic              bus_req, bus_wr;
	logic [31:0]       ufl_wide;

	function automatic logic tag_hit(input logic [TYPE_W-1:0] t, input logic [TAG_W-1:0] tag);
		tag_hit = (t != '0) && ({1'b0, t} == tag);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				m[8*b +: 8] = nw[8*b +: 8];
			end
		end
		merge = m;
	endfunction

	assign fmt       = instr_i[FMT_LSB +: 3];
	assign opc       = instr_i[OPC_LSB +: 6];
	assign type_f    = instr_i[TYPE_LSB +: TYPE_W];
	assign is_rr     = (fmt == FMT_RR);
	assign is_ril    = (fmt == FMT_RIL);
	assign fmt_ok    = is_rr || is_ril;
	assign is_ret    = (opc == OPC_RETURN) || (opc == OPC_RET_SUBVERT);
	assign is_rsv    = (opc == OPC_RET_SUBVERT);
	assign is_call   = (opc == OPC_CALL);
	assign stack_top = ret_stack[wbp_r];
	assign ufl_hit   = (wbp_r == ufl_r);
	assign cls_copy  = (class_i == CLS_ARITH) || (class_i == CLS_LOGIC) || (class_i == CLS_BITBYTE) ||
	                   (class_i == CLS_COP_RD) || (class_i == CLS_LOAD);
	assign bus_req   = wb_cyc_i && wb_stb_i && !ack_r;
	// Writes commit at the edge where the master sees ack, while the request still stands
	assign bus_wr    = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
	assign ufl_wide  = merge({{(32-WBP_W){1'b0}}, ufl_r}, wb_dat_i, wb_sel_i);

	// Immediate never checked; subverted return checks nothing, subverted call checks trap result
	always_comb begin
		if (subvert_r && is_ret) begin
			tag_trap = 1'b0;
		end else if (subvert_r && is_call) begin
			tag_trap = tag_hit(type_f, trap_res_r[DATA_W +: TAG_W]);
		end else begin
			tag_trap = tag_hit(type_f, src1_i[DATA_W +: TAG_W]) ||
			           (is_rr && tag_hit(type_f, src2_i[DATA_W +: TAG_W]));
		end
	end

	assign exec_ret_ok  = instr_valid_i && is_ret && fmt_ok && !ufl_hit && !tag_trap;
	assign exec_call_ok = instr_valid_i && is_call && fmt_ok && !tag_trap;

	////////////////////////////////////////////////////////////////////////////////
	// Execution next state
	always_comb begin
		pc_load_nxt   = 1'b0;
		pc_nxt        = pc_r;
		rf_we_nxt     = 1'b0;
		rf_waddr_nxt  = rf_waddr_r;
		rf_wdata_nxt  = rf_wdata_r;
		br_nxt        = 1'b0;
		inhibit_nxt   = 1'b0;
		trap_nxt      = 1'b0;
		trap_code_nxt = TRAP_NONE;
		nargs_nxt     = nargs_r;
		wbp_nxt       = wbp_r;
		subvert_nxt   = subvert_r;
		push_en       = 1'b0;
		push_idx      = wbp_r + 1'b1;
		push_val      = is_rr ? pc_i + 32'h0000_0001 : pc_i + 32'h0000_0002;
		// Flag spans exactly one instruction; a bus write in the same cycle wins
		if (instr_valid_i && subvert_r) begin
			subvert_nxt = 1'b0;
		end
		// Bus access to pointer and flag; instruction effects below override
		if (bus_wr && wb_adr_i == REG_WBP && wb_sel_i[0]) begin
			wbp_nxt = wb_dat_i[WBP_W-1:0];
		end
		if (bus_wr && wb_adr_i == REG_STATUS && wb_sel_i[0]) begin
			subvert_nxt = wb_dat_i[SUBV_BIT];
		end
		if (instr_valid_i) begin
			if ((is_ret || is_call) && !fmt_ok) begin
				trap_nxt      = 1'b1;
				trap_code_nxt = TRAP_FMT;
			end else if (is_ret && ufl_hit) begin
				trap_nxt      = 1'b1;
				trap_code_nxt = TRAP_UFL;
			end else if ((is_ret || is_call) && tag_trap) begin
				trap_nxt      = 1'b1;
				trap_code_nxt = TRAP_TAG;
			end else if (is_ret) begin
				pc_load_nxt  = 1'b1;
				pc_nxt       = stack_top;
				wbp_nxt      = wbp_r - 1'b1;
				rf_we_nxt    = 1'b1;
				rf_waddr_nxt = instr_i[DEST_LSB +: 6];
				if (subvert_r) begin
					rf_wdata_nxt = trap_res_r;
				end else if (is_rr) begin
					rf_wdata_nxt = {src1_i[DATA_W +: TAG_W], src2_i[DATA_W-1:0]};
				end else begin
					rf_wdata_nxt = imm_i;
				end
				if (instr_i[NARG_LSB + 5]) begin
					nargs_nxt = instr_i[NARG_LSB +: 5];
				end
				if (is_rsv) begin
					subvert_nxt = 1'b1;
				end
			end else if (is_call) begin
				push_en      = 1'b1;
				wbp_nxt      = wbp_r + 1'b1;
				pc_load_nxt  = is_ril;
				pc_nxt       = is_ril ? imm_i[DATA_W-1:0] : pc_r;
				rf_we_nxt    = 1'b1;
				rf_waddr_nxt = instr_i[DEST_LSB +: 6];
				rf_wdata_nxt = subvert_r ? trap_res_r : src1_i;
				if (instr_i[NARG_LSB + 5]) begin
					nargs_nxt = instr_i[NARG_LSB +: 5];
				end
			end else if (subvert_r) begin
				if (cls_copy) begin
					rf_we_nxt    = 1'b1;
					rf_waddr_nxt = instr_i[DEST_LSB +: 6];
					rf_wdata_nxt = trap_res_r;
					inhibit_nxt  = 1'b1;
				end else if (class_i == CLS_COND) begin
					br_nxt      = trap_res_r[0] ^ instr_i[COND_MSB];
					pc_load_nxt = trap_res_r[0] ^ instr_i[COND_MSB];
					pc_nxt      = {pc_i[DATA_W-1:12], instr_i[11:0]};
					inhibit_nxt = 1'b1;
				end else if (class_i == CLS_STORE) begin
					inhibit_nxt = 1'b1;
				end
				// Remaining classes: flag is dropped, nothing else defined
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register file for the bus
	always_comb begin
		ufl_nxt      = ufl_r;
		trap_res_nxt = trap_res_r;
		ack_nxt      = bus_req;
		rdat_nxt     = RST_ZERO;
		if (bus_wr) begin
			unique case (wb_adr_i)
				REG_UFL:   ufl_nxt = ufl_wide[WBP_W-1:0];
				REG_TR_LO: trap_res_nxt[DATA_W-1:0] = merge(trap_res_r[DATA_W-1:0], wb_dat_i, wb_sel_i);
				REG_TR_HI: trap_res_nxt[DATA_W +: TAG_W] = wb_sel_i[0] ? wb_dat_i[TAG_W-1:0]
				                                                  : trap_res_r[DATA_W +: TAG_W];
				default:   ;
			endcase
		end
		if (bus_req && !wb_we_i) begin
			unique case (wb_adr_i)
				REG_STATUS: rdat_nxt = {31'h0000_0000, subvert_r};
				REG_WBP:    rdat_nxt = {{(32-WBP_W){1'b0}}, wbp_r};
				REG_UFL:    rdat_nxt = {{(32-WBP_W){1'b0}}, ufl_r};
				REG_TR_LO:  rdat_nxt = trap_res_r[DATA_W-1:0];
				REG_TR_HI:  rdat_nxt = {26'h000_0000, trap_res_r[DATA_W +: TAG_W]};
				REG_NARGS:  rdat_nxt = {27'h000_0000, nargs_r};
				default:    rdat_nxt = RST_ZERO;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wbp_r       <= '0;
			ufl_r       <= '0;
			trap_res_r  <= '0;
			subvert_r   <= 1'b0;
			nargs_r     <= '0;
			ack_r       <= 1'b0;
			rdat_r      <= RST_ZERO;
			pc_load_r   <= 1'b0;
			pc_r        <= '0;
			rf_we_r     <= 1'b0;
			rf_waddr_r  <= '0;
			rf_wdata_r  <= '0;
			br_r        <= 1'b0;
			inhibit_r   <= 1'b0;
			trap_r      <= 1'b0;
			trap_code_r <= TRAP_NONE;
		end else begin
			wbp_r       <= wbp_nxt;
			ufl_r       <= ufl_nxt;
			trap_res_r  <= trap_res_nxt;
			subvert_r   <= subvert_nxt;
			nargs_r     <= nargs_nxt;
			ack_r       <= ack_nxt;
			rdat_r      <= rdat_nxt;
			pc_load_r   <= pc_load_nxt;
			pc_r        <= pc_nxt;
			rf_we_r     <= rf_we_nxt;
			rf_waddr_r  <= rf_waddr_nxt;
			rf_wdata_r  <= rf_wdata_nxt;
			br_r        <= br_nxt;
			inhibit_r   <= inhibit_nxt;
			trap_r      <= trap_nxt;
			trap_code_r <= trap_code_nxt;
		end
	end

	// Return stack storage, no reset needed
	always_ff @(posedge clk_i) begin
		if (push_en) begin
			ret_stack[push_idx] <= push_val;
		end
	end

	assign wb_dat_o          = rdat_r;
	assign wb_ack_o          = ack_r;
	assign pc_load_o         = pc_load_r;
	assign pc_o              = pc_r;
	assign rf_we_o           = rf_we_r;
	assign rf_waddr_o        = rf_waddr_r;
	assign rf_wdata_o        = rf_wdata_r;
	assign nargs_o           = nargs_r;
	assign branch_take_o     = br_r;
	assign side_fx_inhibit_o = inhibit_r;
	assign trap_o            = trap_r;
	assign trap_code_o       = trap_code_r;
	assign subvert_o         = subvert_r;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_ret_pc_pop: assert property (exec_ret_ok |=> pc_load_o && pc_o == $past(stack_top))
		else $error("return did not load pc from stack top");
	a_ret_wbp_dec: assert property (exec_ret_ok |=> wbp_r == $past(wbp_r) - 1'b1)
		else $error("return did not decrement window pointer");
	a_ufl_trap_raise: assert property (instr_valid_i && is_ret && fmt_ok && ufl_hit
		|=> trap_o && trap_code_o == TRAP_UFL && !pc_load_o && !rf_we_o)
		else $error("underflow trap missing");
	a_nargs_load: assert property (exec_ret_ok && instr_i[NARG_LSB + 5]
		|=> nargs_o == $past(instr_i[NARG_LSB +: 5]))
		else $error("argument count not loaded");
	a_nargs_keep: assert property (exec_ret_ok && !instr_i[NARG_LSB + 5] |=> $stable(nargs_o))
		else $error("argument count changed");
	a_ret_dest_merge: assert property (exec_ret_ok && is_rr && !subvert_r
		|=> rf_we_o && rf_wdata_o == $past({src1_i[DATA_W +: TAG_W], src2_i[DATA_W-1:0]}))
		else $error("register format result wrong");
	a_ret_dest_imm: assert property (exec_ret_ok && is_ril && !subvert_r
		|=> rf_we_o && rf_wdata_o == $past(imm_i))
		else $error("long immediate result wrong");
	a_subv_set_flag: assert property (exec_ret_ok && is_rsv |=> subvert_o)
		else $error("subvert flag not set");
	a_subv_copy_res: assert property (instr_valid_i && subvert_r && cls_copy && !is_ret && !is_call
		|=> rf_we_o && rf_wdata_o == $past(trap_res_r) && side_fx_inhibit_o && !trap_o)
		else $error("subverted copy class wrong");
	a_subv_cond_br: assert property (instr_valid_i && subvert_r && class_i == CLS_COND && !is_ret && !is_call
		|=> branch_take_o == $past(trap_res_r[0] ^ instr_i[COND_MSB]) && !trap_o)
		else $error("subverted branch decision wrong");
	a_subv_store_nop: assert property (instr_valid_i && subvert_r && class_i == CLS_STORE && !is_ret && !is_call
		|=> !rf_we_o && !pc_load_o && !trap_o)
		else $error("subverted store had an effect");
	a_subv_one_instr: assert property (instr_valid_i && subvert_r && !is_rsv && !bus_wr |=> !subvert_o)
		else $error("subvert flag outlived one instruction");
	a_call_push_inc: assert property (exec_call_ok |=> wbp_r == $past(wbp_r) + 1'b1 ##0
		ret_stack[wbp_r] == $past(push_val))
		else $error("call did not push return address");

	c_plain_return: cover property (exec_ret_ok && !is_rsv);
	c_return_subvert: cover property (exec_ret_ok && is_rsv ##[1:20] instr_valid_i && subvert_r);
	c_underflow: cover property (instr_valid_i && is_ret && ufl_hit);
	c_subv_branch: cover property (instr_valid_i && subvert_r && class_i == CLS_COND);

endmodule

// file: rtl/rse_pkg.sv
// Constants for the return and return-subvert execution block.
// Assumes a 40-bit instruction word, 38-bit tagged data words and 32-bit program counters.
package rse_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Word layout
	localparam int WORD_W   = 38;
	localparam int TAG_W    = 6;
	localparam int DATA_W   = 32;
	localparam int INSTR_W  = 40;
	localparam int FMT_LSB  = 34;
	localparam int OPC_LSB  = 28;
	localparam int TYPE_LSB = 12;
	localparam int TYPE_W   = 5;
	localparam int NARG_LSB = 6;
	localparam int DEST_LSB = 0;
	localparam int COND_MSB = 16;

	////////////////////////////////////////////////////////////////////////////////
	// Opcodes and formats
	localparam logic [5:0] OPC_CALL        = 6'h3D;
	localparam logic [5:0] OPC_RETURN      = 6'h3E;
	localparam logic [5:0] OPC_RET_SUBVERT = 6'h3F;
	localparam logic [2:0] FMT_RR          = 3'h6;
	localparam logic [2:0] FMT_RIL         = 3'h5;

	////////////////////////////////////////////////////////////////////////////////
	// Instruction classes from decode
	localparam logic [3:0] CLS_OTHER   = 4'h0;
	localparam logic [3:0] CLS_ARITH   = 4'h1;
	localparam logic [3:0] CLS_LOGIC   = 4'h2;
	localparam logic [3:0] CLS_BITBYTE = 4'h3;
	localparam logic [3:0] CLS_COP_RD  = 4'h4;
	localparam logic [3:0] CLS_LOAD    = 4'h5;
	localparam logic [3:0] CLS_COND    = 4'h6;
	localparam logic [3:0] CLS_STORE   = 4'h7;

	////////////////////////////////////////////////////////////////////////////////
	// Trap codes
	localparam logic [1:0] TRAP_NONE = 2'h0;
	localparam logic [1:0] TRAP_TAG  = 2'h1;
	localparam logic [1:0] TRAP_UFL  = 2'h2;
	localparam logic [1:0] TRAP_FMT  = 2'h3;

	////////////////////////////////////////////////////////////////////////////////
	// Register offsets and reset values
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_WBP    = 8'h04;
	localparam logic [7:0] REG_UFL    = 8'h08;
	localparam logic [7:0] REG_TR_LO  = 8'h0C;
	localparam logic [7:0] REG_TR_HI  = 8'h10;
	localparam logic [7:0] REG_NARGS  = 8'h14;
	localparam int         SUBV_BIT   = 0;
	localparam logic [31:0] RST_ZERO  = 32'h0000_0000;

endpackage

// file: tb/rse_dec_model.sv
// Decode-side model: presents one instruction with its operands to the execution block.
// Assumes the bench calls issue() and that the block takes the instruction at the next rising edge.
`timescale 1ns/1ps
module rse_dec_model
	import rse_pkg::*;
(
	// Clock
	input  wire logic                clk_i,
	// Instruction and operands
	output logic                     valid_o,
	output logic      [INSTR_W-1:0]  instr_o,
	output logic      [WORD_W-1:0]   imm_o,
	output logic      [3:0]          class_o,
	output logic      [DATA_W-1:0]   pc_o,
	output logic      [WORD_W-1:0]   src1_o,
	output logic      [WORD_W-1:0]   src2_o
);

	initial begin
		valid_o = 1'h0;
		instr_o = '0;
		imm_o   = '0;
		class_o = 4'h0;
		pc_o    = 32'h0;
		src1_o  = '0;
		src2_o  = '0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One instruction per call; trap software hands in subvert returns as any other
	task automatic issue(input logic [INSTR_W-1:0] ins, input logic [WORD_W-1:0] imm, input logic [3:0] cls,
		input logic [DATA_W-1:0] pc, input logic [WORD_W-1:0] s1, input logic [WORD_W-1:0] s2);
		@(posedge clk_i);
		valid_o <= 1'h1;
		instr_o <= ins;
		imm_o   <= imm;
		class_o <= cls;
		pc_o    <= pc;
		src1_o  <= s1;
		src2_o  <= s2;
		@(posedge clk_i);
		// Stale operands are inverted so nothing reuses them
		valid_o <= 1'h0;
		instr_o <= ~ins;
		imm_o   <= ~imm;
		src1_o  <= ~s1;
		src2_o  <= ~s2;
	endtask

endmodule

// file: tb/return_and_subvert_exec_tb.sv
// Self-checking bench for the return and return-subvert execution block.
// Assumes the decode model in rse_dec_model and Wishbone register access.
`timescale 1ns/1ps
module return_and_subvert_exec_tb;
	import rse_pkg::*;

	localparam logic [37:0] S1  = {6'h15, 32'hAAAA_0001};
	localparam logic [37:0] S2  = {6'h07, 32'h5555_0002};
	localparam logic [37:0] IMM = {6'h15, 32'hC0DE_0003};
	localparam logic [37:0] TR  = {6'h0A, 32'h1234_5678};

	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, instr_valid_i;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i, class_i;
	logic [31:0] wb_dat_i, wb_dat_o, pc_i, pc_o, q;
	logic [INSTR_W-1:0] instr_i;
	logic [WORD_W-1:0] imm_i, src1_i, src2_i, rf_wdata_o;
	logic wb_ack_o, pc_load_o, rf_we_o, branch_take_o, side_fx_inhibit_o, trap_o, subvert_o;
	logic [5:0] rf_waddr_o;
	logic [4:0] nargs_o;
	logic [1:0] trap_code_o;
	int fails, check_count, cyc_cnt;

	rse_exec #(.WBP_W(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .instr_valid_i(instr_valid_i), .instr_i(instr_i), .imm_i(imm_i), .class_i(class_i),
		.pc_i(pc_i), .src1_i(src1_i), .src2_i(src2_i), .pc_load_o(pc_load_o), .pc_o(pc_o), .rf_we_o(rf_we_o),
		.rf_waddr_o(rf_waddr_o), .rf_wdata_o(rf_wdata_o), .nargs_o(nargs_o), .branch_take_o(branch_take_o),
		.side_fx_inhibit_o(side_fx_inhibit_o), .trap_o(trap_o), .trap_code_o(trap_code_o), .subvert_o(subvert_o));

	rse_dec_model u_dec (.clk_i(clk_i), .valid_o(instr_valid_i), .instr_o(instr_i), .imm_o(imm_i),
		.class_o(class_i), .pc_o(pc_i), .src1_o(src1_i), .src2_o(src2_i));

	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	task automatic chk(input string nm, input logic [37:0] s, input logic [37:0] e);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'hF;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'h1 && n < 20);
		if (n >= 20) fails++;
		q = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
	endtask

	function automatic logic [INSTR_W-1:0] mk(input logic [2:0] f, input logic [5:0] o, input logic [4:0] t,
		input logic [5:0] n);
		return {3'h0, f, o, 11'h000, t, n, 6'h0F};
	endfunction

	task automatic ex(input logic [INSTR_W-1:0] ins, input logic [3:0] cls, input logic [31:0] pc,
		input logic [37:0] s1);
		u_dec.issue(ins, IMM, cls, pc, s1, S2);
		#1;
	endtask

	task automatic res(input logic pl, input logic [31:0] pc, input logic we, input logic [37:0] wd,
		input logic tp, input logic [1:0] cd);
		chk("pc_load", pc_load_o, pl);
		if (pl) chk("pc", pc_o, pc);
		chk("rf_we", rf_we_o, we);
		if (we) chk("rf_wdata", rf_wdata_o, wd);
		if (we) chk("rf_waddr", rf_waddr_o, 6'h0F);
		chk("trap", trap_o, tp);
		if (tp) chk("trap_code", trap_code_o, cd);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Clock and timeout
	initial begin
		clk_i = 1'h0;
		forever #4 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 5000) begin
			fails++;
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		rst_i = 1'h1;
		wb_cyc_i = 1'h0;
		wb_stb_i = 1'h0;
		wb_we_i = 1'h0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'h0;
		#1;
		chk("subvert", subvert_o, 1'h0);
		wb(1'h0, 8'hFC, 32'h0);
		chk("unmapped", q, 32'h0);
		wb(1'h1, REG_TR_LO, TR[31:0]);
		wb(1'h1, REG_TR_HI, {26'h0, TR[37:32]});
		ex(mk(FMT_RR, OPC_CALL, 5'h00, 6'h00), CLS_OTHER, 32'h100, S1);
		ex(mk(FMT_RIL, OPC_CALL, 5'h00, 6'h00), CLS_OTHER, 32'h200, S1);
		wb(1'h0, REG_WBP, 32'h0);
		chk("wbp", q, 32'h2);
		ex(mk(FMT_RR, OPC_RETURN, 5'h00, 6'h23), CLS_OTHER, 32'h300, S1);
		res(1'h1, 32'h202, 1'h1, {S1[37:32], S2[31:0]}, 1'h0, TRAP_NONE);
		chk("nargs", nargs_o, 5'h03);
		wb(1'h0, REG_WBP, 32'h0);
		chk("wbp", q, 32'h1);
		ex(mk(FMT_RIL, OPC_RET_SUBVERT, 5'h00, 6'h05), CLS_OTHER, 32'h300, S1);
		res(1'h1, 32'h101, 1'h1, IMM, 1'h0, TRAP_NONE);
		chk("nargs", nargs_o, 5'h03);
		chk("subvert", subvert_o, 1'h1);
		ex(mk(FMT_RR, 6'h01, 5'h15, 6'h00), CLS_ARITH, 32'h101, S1);
		res(1'h0, 32'h0, 1'h1, TR, 1'h0, TRAP_NONE);
		chk("inhibit", side_fx_inhibit_o, 1'h1);
		@(posedge clk_i);
		#1;
		chk("subvert", subvert_o, 1'h0);
		ex(mk(FMT_RR, OPC_RETURN, 5'h00, 6'h00), CLS_OTHER, 32'h300, S1);
		res(1'h0, 32'h0, 1'h0, '0, 1'h1, TRAP_UFL);
		wb(1'h1, REG_WBP, 32'h2);
		ex(mk(FMT_RR, OPC_RETURN, 5'h15, 6'h00), CLS_OTHER, 32'h300, S1);
		res(1'h0, 32'h0, 1'h0, '0, 1'h1, TRAP_TAG);
		ex(mk(FMT_RIL, OPC_RETURN, 5'h15, 6'h00), CLS_OTHER, 32'h300, S2);
		res(1'h1, 32'h202, 1'h1, IMM, 1'h0, TRAP_NONE);
		ex(mk(3'h7, OPC_RETURN, 5'h00, 6'h00), CLS_OTHER, 32'h300, S1);
		res(1'h0, 32'h0, 1'h0, '0, 1'h1, TRAP_FMT);
		wb(1'h1, REG_WBP, 32'h2);
		ex(mk(FMT_RR, OPC_RET_SUBVERT, 5'h00, 6'h00), CLS_OTHER, 32'h300, S1);
		ex(mk(FMT_RR, 6'h02, 5'h10, 6'h00), CLS_COND, 32'h202, S1);
		chk("branch", branch_take_o, 1'h1);
		ex(mk(FMT_RR, OPC_RET_SUBVERT, 5'h00, 6'h00), CLS_OTHER, 32'h300, S1);
		ex(mk(FMT_RR, 6'h03, 5'h15, 6'h00), CLS_STORE, 32'h101, S1);
		res(1'h0, 32'h0, 1'h0, '0, 1'h0, TRAP_NONE);
		chk("inhibit", side_fx_inhibit_o, 1'h1);
		wb(1'h1, REG_WBP, 32'h2);
		ex(mk(FMT_RR, OPC_RET_SUBVERT, 5'h00, 6'h00), CLS_OTHER, 32'h300, S1);
		ex(mk(FMT_RR, OPC_RETURN, 5'h15, 6'h21), CLS_OTHER, 32'h202, S1);
		res(1'h1, 32'h101, 1'h1, TR, 1'h0, TRAP_NONE);
		wb(1'h1, REG_WBP, 32'h2);
		ex(mk(FMT_RR, OPC_RET_SUBVERT, 5'h00, 6'h00), CLS_OTHER, 32'h300, S1);
		ex(mk(FMT_RR, OPC_CALL, 5'h0A, 6'h00), CLS_OTHER, 32'h202, S2);
		res(1'h0, 32'h0, 1'h0, '0, 1'h1, TRAP_TAG);
		ex(mk(FMT_RR, OPC_RET_SUBVERT, 5'h00, 6'h00), CLS_OTHER, 32'h300, S1);
		ex(mk(FMT_RR, OPC_CALL, 5'h00, 6'h00), CLS_OTHER, 32'h202, S2);
		res(1'h0, 32'h0, 1'h1, TR, 1'h0, TRAP_NONE);
		ex(mk(FMT_RR, OPC_RET_SUBVERT, 5'h00, 6'h00), CLS_OTHER, 32'h300, S1);
		res(1'h1, 32'h203, 1'h1, {S1[37:32], S2[31:0]}, 1'h0, TRAP_NONE);
		ex(mk(FMT_RR, 6'h02, 5'h00, 6'h00), CLS_COND, 32'h203, S1);
		chk("branch", branch_take_o, 1'h0);
		chk("pc_load", pc_load_o, 1'h0);
		stop_test();
	end

endmodule
